// ### common/wsg_defs.vh
`ifndef WSG_DEFS_VH
`define WSG_DEFS_VH
// ==================================================
// Register offsets (memory-mapped register addresses)
`define WSG_CFG_ADDR 16'h0028
`define WSG_CTL_ADDR 16'h002B
// ==================================================
// Reset values
`define WSG_CFG_RESET 16'h7FFF
`define WSG_CTL_RESET 16'h0000
// ==================================================
// Field positions in wait_state_config; WSG_MULT_BIT is the bit position in the control word
`define WSG_EXT_PROG_BIT 15
`define WSG_IO_LSB 12
`define WSG_DHI_LSB 9
`define WSG_DLO_LSB 6
`define WSG_PHI_LSB 3
`define WSG_PLO_LSB 0
`define WSG_MULT_BIT 0
// ==================================================
// Access space codes
`define WSG_SP_PROG 2'h0
`define WSG_SP_DATA 2'h1
`define WSG_SP_IO 2'h2
// Extended program range limit 00000h..3FFFFh (address bits 22:18 zero)
`define WSG_XP_TOP_LSB 18
`endif

// ### src/wsg_counter.v
`timescale 1ns/10ps
// ==================================================
// Counts one bus cycle's wait states down and flags completion
module wsg_counter #(
	parameter CW = 4
) (
	input wire i_ref_clk,
	input wire i_reset,
	input wire i_start,
	input wire [CW-1:0] i_count,
	output reg o_busy,
	output reg o_done
);
	reg [CW-1:0] left_reg;
	// Zero count finishes in the start cycle's next edge, no stretch
	always @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			left_reg <= {CW{1'b0}};
			o_busy <= 1'b0;
			o_done <= 1'b0;
		end else begin
			o_done <= 1'b0;
			if (i_start && !o_busy) begin
				if (i_count == {CW{1'b0}}) begin
					o_done <= 1'b1;
				end else begin
					left_reg <= i_count;
					o_busy <= 1'b1;
				end
			end else if (o_busy) begin
				left_reg <= left_reg - {{(CW-1){1'b0}}, 1'b1};
				if (left_reg == {{(CW-1){1'b0}}, 1'b1}) begin
					o_busy <= 1'b0;
					o_done <= 1'b1;
				end
			end
		end
	end
endmodule

// ### src/wsg_top.v
`timescale 1ns/10ps
`include "wsg_defs.vh"
module wsg_top #(
	parameter AW = 23
) (
	input wire i_ref_clk,
	input wire i_reset,
	input wire i_owner_b,
	input wire i_mmr_wr,
	input wire i_mmr_rd,
	input wire i_mmr_sub_b,
	input wire [15:0] i_mmr_addr,
	input wire [15:0] i_mmr_wdata,
	input wire i_acc_start,
	input wire [1:0] i_acc_space,
	input wire [AW-1:0] i_acc_addr,
	output reg [15:0] o_mmr_rdata,
	output reg o_acc_busy,
	output reg o_acc_done,
	output reg [3:0] o_wait_count
);
	// ==================================================
	// Per-subsystem registers (index 0 is A, 1 is B)
	reg [15:0] cfg_reg [0:1];
	reg [1:0] mult_reg;
	wire cnt_busy;
	wire cnt_done;
	reg [15:0] sel_cfg;
	reg sel_mult;
	reg [2:0] base;
	reg [3:0] eff;
	reg hit;
	integer k;

	// ==================================================
	// Helpers shared by the range decode
	// Extracts a three-bit base count from a config word
	function [2:0] fld;
		input [15:0] v;
		input integer lsb;
		begin
			fld = v[lsb +: 3];
		end
	endfunction

	// Applies the multiplier; a shift, so seven doubles to fourteen at most
	// A shift keeps the path short, no adder sits between config and counter
	function [3:0] scale;
		input [2:0] b;
		input m;
		begin
			if (m) begin
				scale = {b, 1'b0};
			end else begin
				scale = {1'b0, b};
			end
		end
	endfunction

	// True when a program address lies in the extended low range
	// Only the bits above the range limit are compared, so the test is cheap
	function ext_low;
		input [AW-1:0] a;
		begin
			ext_low = (a[AW-1:`WSG_XP_TOP_LSB] == {(AW-`WSG_XP_TOP_LSB){1'b0}});
		end
	endfunction

	// ==================================================
	// Register bank
	// Each subsystem keeps its own config and multiplier so that a change of
	// owner takes effect at once, without software reloading anything.
	// Writes to other addresses fall through untouched.

	// Register writes; control word keeps only the multiplier bit
	always @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			for (k = 0; k < 2; k = k + 1) begin
				cfg_reg[k] <= `WSG_CFG_RESET;
			end
			mult_reg <= 2'b00;
		end else if (i_mmr_wr) begin
			if (i_mmr_addr == `WSG_CFG_ADDR) begin
				cfg_reg[i_mmr_sub_b] <= i_mmr_wdata;
			end
			if (i_mmr_addr == `WSG_CTL_ADDR) begin
				mult_reg[i_mmr_sub_b] <= i_mmr_wdata[`WSG_MULT_BIT];
			end
		end
	end

	// Read data registered; unmapped addresses read zero
	always @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			o_mmr_rdata <= 16'h0000;
		end else if (i_mmr_rd && i_mmr_addr == `WSG_CFG_ADDR) begin
			o_mmr_rdata <= cfg_reg[i_mmr_sub_b];
		end else if (i_mmr_rd && i_mmr_addr == `WSG_CTL_ADDR) begin
			o_mmr_rdata <= {15'h0000, mult_reg[i_mmr_sub_b]};
		end else begin
			o_mmr_rdata <= 16'h0000;
		end
	end

	// ==================================================
	// Range decode: owner's settings pick the base count
	// Purely combinational so a start edge sees the count at once; the
	// owner select must therefore be stable around each start.
	always @* begin
		sel_cfg = cfg_reg[i_owner_b];
		sel_mult = mult_reg[i_owner_b];
		base = 3'h0;
		hit = 1'b1;
		case (i_acc_space)
			`WSG_SP_IO: begin
				base = fld(sel_cfg, `WSG_IO_LSB);
			end
			`WSG_SP_DATA: begin
				if (i_acc_addr[15]) begin
					base = fld(sel_cfg, `WSG_DHI_LSB);
				end else begin
					base = fld(sel_cfg, `WSG_DLO_LSB);
				end
			end
			`WSG_SP_PROG: begin
				// Select clear: page halves by address bit 15
				if (!sel_cfg[`WSG_EXT_PROG_BIT]) begin
					if (i_acc_addr[15]) begin
						base = fld(sel_cfg, `WSG_PHI_LSB);
					end else begin
						base = fld(sel_cfg, `WSG_PLO_LSB);
					end
				end else if (ext_low(i_acc_addr)) begin
					// Select set: low field covers the whole extended low range
					base = fld(sel_cfg, `WSG_PLO_LSB);
				end else begin
					hit = 1'b0; // Upper field ignored when select set
				end
			end
			default: begin
				// No external space: the cycle completes with no stretch
				hit = 1'b0;
			end
		endcase
		// Doubling reaches at most fourteen
		if (hit) begin
			eff = scale(base, sel_mult);
		end else begin
			eff = 4'h0;
		end
	end

	// ==================================================
	// Wait counter
	// The counter ignores starts while busy, so a stray start in mid-cycle
	// cannot shorten or restart the stretch already under way.

	// Stretches the bus cycle by eff cycles
	wsg_counter #(
		.CW(4)
	) u_cnt (
		.i_ref_clk(i_ref_clk),
		.i_reset(i_reset),
		.i_start(i_acc_start),
		.i_count(eff),
		.o_busy(cnt_busy),
		.o_done(cnt_done)
	);

	// ==================================================
	// Registered access status outputs
	// Busy and done lag the counter by one cycle so every output is a flip-flop
	always @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			o_acc_busy <= 1'b0;
			o_acc_done <= 1'b0;
			o_wait_count <= 4'h0;
		end else begin
			o_acc_busy <= cnt_busy;
			o_acc_done <= cnt_done;
			if (i_acc_start && !cnt_busy) begin
				o_wait_count <= eff;
			end
		end
	end
endmodule

// ### testbench/wsg_slow_mem.sv
`timescale 1ns/10ps
// ==========
// Slow device: counts cycles its bus cycle is held open
module wsg_slow_mem (input wire i_ref_clk, input wire i_reset, input wire i_busy, input wire i_done,
	output reg [3:0] o_held);
	// Cleared on the closing strobe so back-to-back cycles count apart
	always @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) o_held <= 4'h0;
		else if (i_done) o_held <= 4'h0;
		else if (i_busy) o_held <= o_held + 4'h1;
	end
endmodule

// ### testbench/wsg_top_properties.sv
`timescale 1ns/10ps
// ==========
// Port checks; the multiplier is internal, so counts tie to o_wait_count
module wsg_chk (input wire i_ref_clk, input wire i_reset, input wire i_mmr_rd, input wire [15:0] i_mmr_addr,
	input wire [15:0] o_mmr_rdata, input wire o_acc_busy, input wire o_acc_done, input wire [3:0] o_wait_count);
	reg [3:0] held_reg;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_reset);
	// Busy cycles seen in the current bus cycle
	always @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) held_reg <= 4'h0;
		else if (o_acc_done) held_reg <= 4'h0;
		else if (o_acc_busy) held_reg <= held_reg + 4'h1;
	end
	property p_max; o_wait_count <= 4'he; endproperty
	a_max: assert property (p_max) else $error("count high");
	property p_end; $rose(o_acc_busy) |-> ##[1:15] o_acc_done; endproperty
	a_end: assert property (p_end) else $error("no done");
	property p_len; o_acc_done |-> held_reg == o_wait_count; endproperty
	a_len: assert property (p_len) else $error("bad length");
	property p_zero; o_acc_done && o_wait_count == 4'h0 |-> !$past(o_acc_busy); endproperty
	a_zero: assert property (p_zero) else $error("busy at zero");
	property p_one; o_acc_done |=> !o_acc_done; endproperty
	a_one: assert property (p_one) else $error("long done");
	property p_excl; !(o_acc_busy && o_acc_done); endproperty
	a_excl: assert property (p_excl) else $error("busy with done");
	property p_rsv; i_mmr_rd && i_mmr_addr == 16'h002b |=> o_mmr_rdata[15:1] == 15'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved set");
	property p_rd; o_mmr_rdata != 16'h0 |-> $past(i_mmr_rd); endproperty
	a_rd: assert property (p_rd) else $error("stray data");
endmodule
bind wsg_top wsg_chk wsg_chk_i (.*);

// ### testbench/wsg_top_tb.sv
`timescale 1ns/10ps
// ==========
// Bench: register bank setup, then timed external accesses
module wsg_top_tb;
	reg c = 0, r = 1, ow = 0, wr = 0, rd = 0, sb = 0, st = 0;
	reg [15:0] ad = 0, wd = 0, q;
	reg [1:0] sp = 0;
	reg [22:0] aa = 0;
	wire [15:0] rq;
	wire bz, dn;
	wire [3:0] wc, hd;
	integer mismatches = 0, samples_checked = 0, n;
	always #2.5 c = ~c;
	wsg_top wsg_top_i (.i_ref_clk(c), .i_reset(r), .i_owner_b(ow), .i_mmr_wr(wr), .i_mmr_rd(rd), .i_mmr_sub_b(sb),
		.i_mmr_addr(ad), .i_mmr_wdata(wd), .i_acc_start(st), .i_acc_space(sp), .i_acc_addr(aa), .o_mmr_rdata(rq),
		.o_acc_busy(bz), .o_acc_done(dn), .o_wait_count(wc));
	wsg_slow_mem wsg_slow_mem_i (.i_ref_clk(c), .i_reset(r), .i_busy(bz), .i_done(dn), .o_held(hd));
	task check(input [15:0] s, e); begin
		samples_checked = samples_checked + 1;
		if (s !== e) begin
			mismatches = mismatches + 1;
			$display("unexpected %0t %h %h", $time, s, e);
		end
	end endtask
	// One register cycle; read data lands one cycle after the request
	task m(input w, b, input [15:0] a, d); begin
		@(posedge c) {wr, rd, sb, ad, wd} <= {w, !w, b, a, d};
		@(posedge c) {wr, rd} <= 2'h0;
		@(negedge c) q = rq;
	end endtask
	// Bounded wait: a lost done must not hang the run
	task x(input [1:0] s, input [22:0] a, input [3:0] e); begin
		@(posedge c) {st, sp, aa} <= {1'h1, s, a};
		@(posedge c) st <= 1'h0;
		for (n = 0; n < 40 && dn !== 1'h1; n = n + 1) @(negedge c);
		check(wc, e);
		check(hd, e);
	end endtask
	task t_fields; begin
		m(0, 0, 16'h0028, 0);
		check(q, 16'h7fff);
		m(0, 0, 16'h002b, 0);
		check(q, 16'h0);
		x(1, 23'h8000, 7);
		m(1, 0, 16'h0028, 16'h14e5);
		m(0, 0, 16'h0028, 0);
		check(q, 16'h14e5);
		x(2, 23'h0, 1);
		x(1, 23'h8000, 2);
		x(1, 23'h0, 3);
		x(0, 23'h1_8000, 4);
		x(0, 23'h1_0000, 5);
	end endtask
	task t_mult; begin
		m(1, 0, 16'h002b, 16'hffff);
		m(0, 0, 16'h002b, 0);
		check(q, 16'h1);
		x(2, 23'h0, 2);
		m(1, 0, 16'h0028, 16'h94e5);
		x(0, 23'h3_8000, 10);
		x(0, 23'h0_8000, 10);
		x(0, 23'h4_0000, 0);
		x(3, 23'h0, 0);
		m(1, 0, 16'h0029, 16'hffff);
		m(0, 0, 16'h0029, 0);
		check(q, 16'h0);
		m(1, 0, 16'h0028, 16'hffff);
		x(2, 23'h0, 14);
		@(posedge c) ow <= 1'h1;
		x(2, 23'h0, 7);
	end endtask
	// Mid-run reset must bring every bank back to its reset contents
	task t_reset; begin
		@(posedge c) r <= 1;
		repeat (2) @(posedge c);
		r <= 0;
		m(0, 0, 16'h0028, 0);
		check(q, 16'h7fff);
		m(0, 0, 16'h002b, 0);
		check(q, 16'h0);
		x(2, 23'h0, 7);
	end endtask
	initial begin
		repeat (16) @(posedge c);
		r <= 0;
		t_fields;
		t_mult;
		t_reset;
		print_verdict;
	end
	initial begin
		#20000;
		mismatches = mismatches + 1;
		print_verdict;
	end
	task print_verdict; begin
		if (mismatches == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	end endtask
endmodule
